// ---- fasm_pkg.sv ----
// Constants and types for the flash address space map.
package fasm_pkg;
  // Address and main array geometry.
  localparam int          ADDR_W       = 24;
  localparam int          SECT_LSB     = 12;
  localparam int          SECT_W       = 11;
  localparam int          SECT_DEFAULT = 512;
  // Security region geometry: region n sits at n * 1000h, 256 bytes long.
  localparam int          REG_LSB      = 12;
  localparam int          REG_W        = 2;
  localparam int          REG_COUNT    = 4;
  localparam int          REG_BYTE_W   = 8;
  // Opcode that selects the discovery space.
  localparam logic [7:0]  OP_DISCOVERY = 8'h5a;
  // Discovery space layout, byte offsets.
  localparam logic [7:0]  SIG_0        = 8'h53;
  localparam logic [7:0]  SIG_1        = 8'h46;
  localparam logic [7:0]  SIG_2        = 8'h44;
  localparam logic [7:0]  SIG_3        = 8'h50;
  localparam logic [7:0]  HDR_MINOR    = 8'h06;
  localparam logic [7:0]  HDR_MAJOR    = 8'h01;
  localparam logic [7:0]  HDR_NPH      = 8'h01;
  localparam logic [7:0]  TBL_LEN      = 8'h04;
  localparam logic [7:0]  PARAM_START  = 8'h80;
  localparam logic [7:0]  BASIC_START  = 8'h90;
  localparam logic [7:0]  MAP_START    = 8'hb0;
  localparam logic [7:0]  PARAM_END    = 8'hbf;
  localparam logic [7:0]  RSVD_START   = 8'hc0;
  localparam logic [7:0]  RSVD_END     = 8'hf7;
  localparam logic [7:0]  UID_START    = 8'hf8;
  localparam logic [7:0]  FILL_BYTE    = 8'hff;
  localparam logic [7:0]  ID_BASIC     = 8'h00;
  localparam logic [7:0]  ID_MAP       = 8'h81;
  // Arbitrary unique identifier default, not tied to any real part.
  localparam logic [63:0] UID_DEFAULT  = 64'h0123_4567_89ab_cdef;
  // Reset values.
  localparam logic [7:0]  DATA_RESET   = 8'h00;
  // Address space selected by a request.
  typedef enum logic [1:0] {
    FASM_MAIN = 2'h0,
    FASM_SEC  = 2'h1,
    FASM_DISC = 2'h3
  } fasm_space_type;
  // Kind of access.
  typedef enum logic [1:0] {
    FASM_READ  = 2'h0,
    FASM_PROG  = 2'h1,
    FASM_ERASE = 2'h3
  } fasm_op_type;
endpackage

// ---- fasm_map.sv ----
// Address decoder and discovery content for the flash address spaces.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Main array erases in uniform 4-kbyte sectors, the smallest erase unit.
// - Sector index comes from address bits above 11; 512, 1024 or 2048 sectors.
// - Four 256-byte security regions sit at n times 1000h.
// - A set lock bit stops any erase or program of its region while it stays set.
// - Region 0 holds the discovery data, same bytes as the discovery read.
// - Regions 1 to 3 erase, program and lock on their own.
// - Opcode 5Ah reads the discovery space instead of the main array.
// - Discovery space is read-only; host erase or program changes nothing.
// - Discovery space opens with a header giving revision and table pointers.
// - Physical order is header, basic table, sector map.
// - One mandatory basic flash table, pointed to by the header.
// - Parameter data starts at byte 80h; defined space ends at BFh.
// - Bytes C0h to F7h are reserved with no defined content.
// - Bytes F8h to FFh return an eight-byte unique identifier.
// - Every separate space takes a full 24-bit address.
// - Header bytes 0 to 3 return 53h, 46h, 44h, 50h.
module fasm_map #(
  parameter int          SECTOR_COUNT = fasm_pkg::SECT_DEFAULT,
  parameter logic [63:0] UNIQUE_ID    = fasm_pkg::UID_DEFAULT
) (
  input  wire logic                        clk_sys,
  input  wire logic                        resetn,
  input  wire logic                        req_valid,
  input  wire logic [7:0]                  req_opcode,
  input  wire logic                        req_security,
  input  wire fasm_pkg::fasm_op_type       req_op,
  input  wire logic [fasm_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [fasm_pkg::REG_COUNT-1:0] lock_bits,
  output logic                             rsp_valid,
  output fasm_pkg::fasm_space_type         rsp_space,
  output logic [fasm_pkg::SECT_W-1:0]      rsp_sector,
  output logic                             rsp_region_hit,
  output logic [fasm_pkg::REG_W-1:0]       rsp_region,
  output logic [fasm_pkg::ADDR_W-1:0]      rsp_base,
  output logic                             rsp_allow,
  output logic [7:0]                       rsp_data
);

  // Discovery content lookup; shared by the discovery read and region 0.
  function automatic logic [7:0] disc_byte(input logic [fasm_pkg::ADDR_W-1:0] a);
    logic [7:0] lo;
    logic [7:0] r;
    lo = a[7:0];
    r  = fasm_pkg::FILL_BYTE;
    if (a[fasm_pkg::ADDR_W-1:8] != '0) begin
      r = fasm_pkg::FILL_BYTE;
    end else if (lo >= fasm_pkg::UID_START) begin
      r = UNIQUE_ID[8*lo[2:0] +: 8];
    end else if (lo >= fasm_pkg::RSVD_START) begin
      r = fasm_pkg::FILL_BYTE;
    end else begin
      case (lo)
        8'h00: r = fasm_pkg::SIG_0;
        8'h01: r = fasm_pkg::SIG_1;
        8'h02: r = fasm_pkg::SIG_2;
        8'h03: r = fasm_pkg::SIG_3;
        8'h04: r = fasm_pkg::HDR_MINOR;
        8'h05: r = fasm_pkg::HDR_MAJOR;
        8'h06: r = fasm_pkg::HDR_NPH;
        8'h08: r = fasm_pkg::ID_BASIC;
        8'h09: r = fasm_pkg::HDR_MINOR;
        8'h0a: r = fasm_pkg::HDR_MAJOR;
        8'h0b: r = fasm_pkg::TBL_LEN;
        8'h0c: r = fasm_pkg::BASIC_START;
        8'h10: r = fasm_pkg::ID_MAP;
        8'h11: r = fasm_pkg::HDR_MINOR;
        8'h12: r = fasm_pkg::HDR_MAJOR;
        8'h13: r = fasm_pkg::TBL_LEN;
        8'h14: r = fasm_pkg::MAP_START;
        fasm_pkg::PARAM_START: r = fasm_pkg::HDR_MAJOR;
        fasm_pkg::PARAM_END:   r = fasm_pkg::FILL_BYTE;
        default: r = fasm_pkg::FILL_BYTE;
      endcase
    end
    return r;
  endfunction

  // Region decode: hit when the address lies in the first 256 bytes of
  // one of the first four 4-kbyte blocks.
  function automatic logic region_hit(input logic [fasm_pkg::ADDR_W-1:0] a);
    return (a[fasm_pkg::ADDR_W-1:fasm_pkg::REG_LSB+fasm_pkg::REG_W] == '0) &&
           (a[fasm_pkg::REG_LSB-1:fasm_pkg::REG_BYTE_W] == '0);
  endfunction

  // Sector mask wraps addresses above the fitted density, as a flash does.
  localparam logic [fasm_pkg::SECT_W-1:0] SECT_MASK =
    fasm_pkg::SECT_W'(SECTOR_COUNT - 1);

  // Request decode.
  wire logic is_disc = (req_opcode == fasm_pkg::OP_DISCOVERY);
  wire fasm_pkg::fasm_space_type space_d =
    is_disc ? fasm_pkg::FASM_DISC :
    (req_security ? fasm_pkg::FASM_SEC : fasm_pkg::FASM_MAIN);
  wire logic [fasm_pkg::SECT_W-1:0] sector_d =
    req_addr[fasm_pkg::SECT_LSB +: fasm_pkg::SECT_W] & SECT_MASK;
  wire logic                       hit_d    = region_hit(req_addr);
  wire logic [fasm_pkg::REG_W-1:0] region_d = req_addr[fasm_pkg::REG_LSB +: fasm_pkg::REG_W];
  wire logic is_write = (req_op != fasm_pkg::FASM_READ);

  // Erase and program base: a sector start for the main array, a region
  // start for a security region.
  wire logic [fasm_pkg::ADDR_W-1:0] base_d =
    (space_d == fasm_pkg::FASM_MAIN) ?
      {1'b0, sector_d, 12'h000} :
      {10'h000, region_d, 12'h000};

  // Write permission. Region 0 is factory data and never writable, so the
  // discovery content cannot drift from what region 0 returns.
  wire logic sec_ok = hit_d && (region_d != '0) && !lock_bits[region_d];
  wire logic allow_d =
    (space_d == fasm_pkg::FASM_MAIN) ? 1'b1 :
    (space_d == fasm_pkg::FASM_SEC)  ? sec_ok : 1'b0;

  // Read data: discovery space and region 0 share one lookup.
  wire logic [7:0] data_d =
    ((space_d == fasm_pkg::FASM_DISC) ||
     ((space_d == fasm_pkg::FASM_SEC) && hit_d && (region_d == '0))) ?
      disc_byte(req_addr) : fasm_pkg::FILL_BYTE;

  // Response registers; one cycle of latency, no stalls.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rsp_valid      <= 1'b0;
      rsp_space      <= fasm_pkg::FASM_MAIN;
      rsp_sector     <= '0;
      rsp_region_hit <= 1'b0;
      rsp_region     <= '0;
      rsp_base       <= '0;
      rsp_allow      <= 1'b0;
      rsp_data       <= fasm_pkg::DATA_RESET;
    end else begin
      rsp_valid      <= req_valid;
      rsp_space      <= space_d;
      rsp_sector     <= sector_d;
      rsp_region_hit <= hit_d;
      rsp_region     <= region_d;
      rsp_base       <= base_d;
      rsp_allow      <= allow_d && is_write && req_valid;
      rsp_data       <= data_d;
    end
  end

  // Checks on the decoded answer, all one cycle after the request.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_sector_index;
    req_valid && !is_disc && !req_security |=>
      rsp_sector == ($past(req_addr[22:12]) & SECT_MASK);
  endproperty
  a_sector_index: assert property (p_sector_index) else $error("sector index wrong");

  property p_erase_align;
    rsp_valid && rsp_space == fasm_pkg::FASM_MAIN |->
      rsp_base[11:0] == 12'h000 && rsp_base[22:12] == rsp_sector;
  endproperty
  a_erase_align: assert property (p_erase_align) else $error("erase base not sector aligned");

  property p_region3;
    req_valid && req_security && !is_disc && req_addr == 24'h0030ff |=>
      rsp_region_hit && rsp_region == 2'h3 && rsp_base == 24'h003000;
  endproperty
  a_region3: assert property (p_region3) else $error("region 3 decode wrong");

  property p_lock_blocks;
    req_valid && req_security && !is_disc && lock_bits[req_addr[13:12]] |=> !rsp_allow;
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked region writable");

  property p_indep;
    req_valid && req_security && !is_disc && req_op == fasm_pkg::FASM_ERASE &&
    req_addr == 24'h002010 && lock_bits == 4'hb |=> rsp_allow;
  endproperty
  a_indep: assert property (p_indep) else $error("open region 2 refused");

  property p_disc_ro;
    rsp_valid && rsp_space == fasm_pkg::FASM_DISC |-> !rsp_allow;
  endproperty
  a_disc_ro: assert property (p_disc_ro) else $error("discovery space writable");

  property p_same_data;
    req_valid && req_security && !is_disc && req_addr[23:8] == 16'h0000 |=>
      rsp_data == disc_byte($past(req_addr));
  endproperty
  a_same_data: assert property (p_same_data) else $error("region 0 differs");

  // The signature is checked at both ends, so one request at a time suffices.
  property p_signature;
    req_valid && is_disc && req_addr == 24'h000000 |=> rsp_data == 8'h53;
  endproperty
  a_signature: assert property (p_signature) else $error("signature wrong");

  property p_signature_end;
    req_valid && is_disc && req_addr == 24'h000003 |=> rsp_data == 8'h50;
  endproperty
  a_signature_end: assert property (p_signature_end) else $error("signature end wrong");

  property p_uid;
    req_valid && is_disc && req_addr == 24'h0000ff |=> rsp_data == UNIQUE_ID[63:56];
  endproperty
  a_uid: assert property (p_uid) else $error("unique id byte wrong");

  property p_reserved;
    req_valid && is_disc && req_addr == 24'h0000c0 |=> rsp_data == fasm_pkg::FILL_BYTE;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved byte wrong");

  property p_pointer;
    req_valid && is_disc && req_addr == 24'h00000c |=> rsp_data == fasm_pkg::BASIC_START;
  endproperty
  a_pointer: assert property (p_pointer) else $error("basic table pointer wrong");

  property p_always_answers;
    req_valid |=> rsp_valid;
  endproperty
  a_always_answers: assert property (p_always_answers) else $error("request not answered");

  // Layout checks on the discovery space; all but p_param_start pin a fixed byte.
  property p_header_rev;
    req_valid && is_disc && req_addr == 24'h000004 |=> rsp_data == fasm_pkg::HDR_MINOR;
  endproperty
  a_header_rev: assert property (p_header_rev) else $error("header revision wrong");

  property p_map_pointer;
    req_valid && is_disc && req_addr == 24'h000014 |=>
      rsp_data == fasm_pkg::MAP_START && fasm_pkg::MAP_START > fasm_pkg::BASIC_START;
  endproperty
  a_map_pointer: assert property (p_map_pointer) else $error("sector map pointer wrong");

  property p_param_start;
    req_valid && is_disc && req_addr == 24'h000080 |=> rsp_data != fasm_pkg::FILL_BYTE;
  endproperty
  a_param_start: assert property (p_param_start) else $error("parameter data missing");

  property p_uid_first;
    req_valid && is_disc && req_addr == 24'h0000f8 |=> rsp_data == UNIQUE_ID[7:0];
  endproperty
  a_uid_first: assert property (p_uid_first) else $error("first unique id byte wrong");

  // Discovery addresses are decoded on all 24 bits, so the high bits never alias.
  property p_disc_high;
    req_valid && is_disc && req_addr[23:8] != 16'h0000 |=> rsp_data == fasm_pkg::FILL_BYTE;
  endproperty
  a_disc_high: assert property (p_disc_high) else $error("high discovery address aliased");

  property p_disc_space;
    req_valid && is_disc |=> rsp_space == fasm_pkg::FASM_DISC;
  endproperty
  a_disc_space: assert property (p_disc_space) else $error("discovery opcode missed");

  // Security region decode; the gap between regions must never hit.
  property p_region1;
    req_valid && req_security && !is_disc && req_addr == 24'h0010ff |=>
      rsp_region_hit && rsp_region == 2'h1 && rsp_base == 24'h001000;
  endproperty
  a_region1: assert property (p_region1) else $error("region 1 decode wrong");

  property p_region_base;
    req_valid && req_security && !is_disc |=>
      rsp_base[11:0] == 12'h000 && rsp_base[23:14] == 10'h000;
  endproperty
  a_region_base: assert property (p_region_base) else $error("region base wrong");

  property p_region_gap;
    req_valid && req_security && !is_disc && req_addr[11:8] != 4'h0 |=>
      !rsp_region_hit && !rsp_allow;
  endproperty
  a_region_gap: assert property (p_region_gap) else $error("gap decoded as region");

  property p_region_far;
    req_valid && req_security && !is_disc && req_addr[23:14] != 10'h000 |=>
      !rsp_region_hit && !rsp_allow;
  endproperty
  a_region_far: assert property (p_region_far) else $error("high address decoded as region");

  // Region 0 stays factory data even while its lock bit is still clear.
  property p_region0_ro;
    req_valid && req_security && !is_disc && req_addr[23:8] == 16'h0000 |=> !rsp_allow;
  endproperty
  a_region0_ro: assert property (p_region0_ro) else $error("region 0 writable");

  // Main array permission and sector span; lock bits must not reach the array.
  property p_main_write;
    req_valid && !is_disc && !req_security && is_write |=>
      rsp_allow && rsp_space == fasm_pkg::FASM_MAIN;
  endproperty
  a_main_write: assert property (p_main_write) else $error("main array write refused");

  property p_lock_main;
    req_valid && !is_disc && !req_security && is_write && lock_bits != '0 |=> rsp_allow;
  endproperty
  a_lock_main: assert property (p_lock_main) else $error("lock bits blocked main array");

  property p_sector_span;
    req_valid && !is_disc && !req_security && req_addr[23:12] < 12'(SECTOR_COUNT) |=>
      ($past(req_addr) - rsp_base) <= 24'h000fff;
  endproperty
  a_sector_span: assert property (p_sector_span) else $error("address outside its sector");

  // Handshake: no answer and no grant without a request, and reads never grant.
  property p_no_request;
    !req_valid |=> !rsp_valid && !rsp_allow;
  endproperty
  a_no_request: assert property (p_no_request) else $error("answer without request");

  property p_read_deny;
    req_valid && req_op == fasm_pkg::FASM_READ |=> !rsp_allow;
  endproperty
  a_read_deny: assert property (p_read_deny) else $error("read granted a write");

  c_disc_read: cover property (req_valid && is_disc ##1 rsp_valid);
  c_sec_write: cover property (req_valid && req_security && is_write ##1 rsp_allow);
  c_locked: cover property (req_valid && req_security && lock_bits != '0 ##1 !rsp_allow);
  c_main_erase: cover property (req_valid && req_op == fasm_pkg::FASM_ERASE && !req_security);
  c_region0_read: cover property (req_valid && req_security && req_addr[23:8] == 16'h0000 ##1 rsp_valid);

endmodule
`default_nettype wire

// ---- fasm_host_model.sv ----
// Host side model that issues single-byte flash requests to the address map.
`timescale 1ns/1ps
`default_nettype none
module fasm_host_model (
  input  wire logic                       clk_sys,
  output var logic                        req_valid,
  output var logic [7:0]                  req_opcode,
  output var logic                        req_security,
  output var fasm_pkg::fasm_op_type       req_op,
  output var logic [fasm_pkg::ADDR_W-1:0] req_addr
);
  // Idle values at time zero; the address holds junk because nothing is selected yet.
  initial begin
    req_valid    = 1'b0;
    req_opcode   = 8'h00;
    req_security = 1'b0;
    req_op       = fasm_pkg::FASM_READ;
    req_addr     = 24'h5a5a5a;
  end
  // One request stands for one edge, then the address is inverted so a stale value never helps the design.
  task automatic xfer(input logic [7:0] opc, input logic sec, input fasm_pkg::fasm_op_type op,
                      input logic [23:0] addr);
    @(posedge clk_sys);
    req_valid    <= 1'b1;
    req_opcode   <= opc;
    req_security <= sec;
    req_op       <= op;
    req_addr     <= addr;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    req_addr  <= ~addr;
    #1;
  endtask
endmodule
`default_nettype wire

// ---- flash_address_space_map_bench.sv ----
// Self-checking bench for the flash address space map.
`timescale 1ns/1ps
`default_nettype none
module flash_address_space_map_bench;
  localparam logic [63:0] UID = 64'hfeed_0bad_1234_5678; // Arbitrary value.
  logic clk_sys, resetn, req_valid, req_security, rsp_valid, rsp_region_hit, rsp_allow;
  logic [7:0] req_opcode, rsp_data;
  logic [3:0] lock_bits;
  logic [1:0] rsp_region;
  logic [10:0] rsp_sector;
  logic [23:0] req_addr, rsp_base;
  fasm_pkg::fasm_op_type req_op;
  fasm_pkg::fasm_space_type rsp_space;
  int failures, checks_done;
  // The host model owns every request input of the map.
  fasm_host_model host_u (.clk_sys(clk_sys), .req_valid(req_valid), .req_opcode(req_opcode),
    .req_security(req_security), .req_op(req_op), .req_addr(req_addr));
  fasm_map #(.SECTOR_COUNT(512), .UNIQUE_ID(UID)) dut_u (.clk_sys(clk_sys), .resetn(resetn),
    .req_valid(req_valid), .req_opcode(req_opcode), .req_security(req_security), .req_op(req_op),
    .req_addr(req_addr), .lock_bits(lock_bits), .rsp_valid(rsp_valid), .rsp_space(rsp_space),
    .rsp_sector(rsp_sector), .rsp_region_hit(rsp_region_hit), .rsp_region(rsp_region),
    .rsp_base(rsp_base), .rsp_allow(rsp_allow), .rsp_data(rsp_data));
  // Free-running 200 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Every request must be answered one edge later, whatever it touches.
  task automatic rq(input logic [7:0] opc, input logic sec, input fasm_pkg::fasm_op_type op, input logic [23:0] a);
    host_u.xfer(opc, sec, op, a);
    chk(24'(rsp_valid), 24'h1);
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] exp);
    rq(8'h5a, 1'b0, fasm_pkg::FASM_READ, a);
    chk(24'(rsp_data), 24'(exp));
    chk(24'(rsp_space), 24'(fasm_pkg::FASM_DISC));
  endtask
  task automatic t_header;
    rd(24'h000000, fasm_pkg::SIG_0);
    rd(24'h000001, fasm_pkg::SIG_1);
    rd(24'h000002, fasm_pkg::SIG_2);
    rd(24'h000003, fasm_pkg::SIG_3);
    rd(24'h000004, fasm_pkg::HDR_MINOR);
    rd(24'h00000c, fasm_pkg::BASIC_START);
    rd(24'h000014, fasm_pkg::MAP_START);
    rd(24'h000080, 8'h01);
    rd(24'h0000c0, fasm_pkg::FILL_BYTE);
    rd(24'h010000, fasm_pkg::FILL_BYTE);
  endtask
  task automatic t_uid;
    for (int k = 0; k < 8; k++) begin
      rd(24'h0000f8 + 24'(k), UID[8*k +: 8]);
    end
  endtask
  // Host writes to the discovery space are never allowed and leave the bytes intact.
  task automatic t_readonly;
    rq(8'h5a, 1'b0, fasm_pkg::FASM_ERASE, 24'h000000);
    chk(24'(rsp_allow), 24'h0);
    rq(8'h5a, 1'b0, fasm_pkg::FASM_PROG, 24'h000001);
    chk(24'(rsp_allow), 24'h0);
    rd(24'h000000, fasm_pkg::SIG_0);
  endtask
  // Region 2 is locked, then regions 0, 1 and 3 with region 2 open; region 0 is never writable.
  task automatic t_regions;
    @(posedge clk_sys);
    lock_bits <= 4'b0100;
    for (int n = 0; n < 4; n++) begin
      rq(8'h44, 1'b1, fasm_pkg::FASM_ERASE, {10'h000, 2'(n), 12'h010});
      chk(24'(rsp_region_hit), 24'h1);
      chk(24'(rsp_region), 24'(n));
      chk(rsp_base, {10'h000, 2'(n), 12'h000});
      chk(24'(rsp_allow), 24'((n == 1) || (n == 3)));
    end
    rq(8'h42, 1'b1, fasm_pkg::FASM_PROG, 24'h002100);
    chk(24'(rsp_region_hit), 24'h0);
    chk(24'(rsp_allow), 24'h0);
    rq(8'h48, 1'b1, fasm_pkg::FASM_READ, 24'h000000);
    chk(24'(rsp_data), 24'(fasm_pkg::SIG_0));
    rq(8'h44, 1'b1, fasm_pkg::FASM_ERASE, 24'h0030ff);
    chk(rsp_base, 24'h003000);
    rq(8'h44, 1'b1, fasm_pkg::FASM_ERASE, 24'h0010ff);
    chk(24'(rsp_region), 24'h1);
    rq(8'h44, 1'b1, fasm_pkg::FASM_ERASE, 24'h013010);
    chk(24'(rsp_region_hit), 24'h0);
    chk(24'(rsp_allow), 24'h0);
    @(posedge clk_sys);
    lock_bits <= 4'hb;
    rq(8'h44, 1'b1, fasm_pkg::FASM_ERASE, 24'h002010);
    chk(24'(rsp_allow), 24'h1);
    rq(8'h44, 1'b1, fasm_pkg::FASM_PROG, 24'h001010);
    chk(24'(rsp_allow), 24'h0);
  endtask
  task automatic t_main;
    rq(8'h20, 1'b0, fasm_pkg::FASM_ERASE, 24'h1ff123);
    chk(24'(rsp_space), 24'(fasm_pkg::FASM_MAIN));
    chk(24'(rsp_sector), 24'd511);
    chk(rsp_base, 24'h1ff000);
    chk(24'(rsp_allow), 24'h1);
    rq(8'h20, 1'b0, fasm_pkg::FASM_ERASE, 24'h000fff);
    chk(24'(rsp_sector), 24'd0);
    chk(rsp_base, 24'h000000);
  endtask
  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Reset for five cycles, then run every scenario in turn.
  initial begin
    failures = 0;
    checks_done = 0;
    resetn = 1'b0;
    lock_bits = 4'h0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    t_header();
    t_uid();
    t_readonly();
    t_regions();
    t_main();
    results();
  end
  // The 34 requests of two cycles each fit well inside this limit.
  initial begin
    #20000;
    failures++;
    results();
  end
endmodule
`default_nettype wire
